// file: logic/nv_switch_core.sv
// serial-bus slave and command logic of the configuration switch
// assumes bus and pins are asynchronous to clk, bus clock well below clk/8
//
// Notes on behaviour
// - address lsb one means read, zero means write
// - two strap pins give the low address bits
// - first written byte after address is the stored command
// - only defined command codes are acknowledged
// - code zero selects first setting
// - code one selects second setting
// - all-ones code selects read-only view of input pins
// - override codes force outputs to first, second or inputs
// - override with low bit set returns control to pick pins
// - every other command code is reserved
// - data byte after setting command is programmed at stop if unlocked
// - second data byte goes to the other setting at stop
// - third data byte is refused and whole write discarded
// - pointer toggles after each setting byte read or written
// - input view reads five inputs, top three bits zero
// - write lock high keeps the settings unchanged
// - first pick pin chooses inputs or stored setting
// - second pick pin chooses which setting
// - an extra output comes from the stored settings
// - pick 0/1 first, 0/0 second, 1/x inputs with latched extra
// - own address refused during programming time after a write
// - locked writes acknowledge address and command, refuse data
// - data after an override command is refused
`timescale 1ns/100ps
`default_nettype none
module nv_switch_core #(
    parameter int PROG_CYCLES = nv_switch_pkg::NV_PROG_CYCLES,
    parameter logic [4:0] ADDR_HIGH = nv_switch_pkg::ADDR_HIGH_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    input wire logic write_lock,
    input wire logic source_pick_0,
    input wire logic source_pick_1,
    input wire logic [nv_switch_pkg::EXT_WIDTH-1:0] ext_in,
    output logic [nv_switch_pkg::EXT_WIDTH-1:0] mux_out,
    output logic nonmux_out
);
    import nv_switch_pkg::*;

    if (PROG_CYCLES < 1) begin : g_bad_prog
        $error("PROG_CYCLES must be positive");
    end

    localparam int SYNC_W = EXT_WIDTH + 7;
    localparam int BUSY_W = $clog2(PROG_CYCLES + 1);

    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_WAIT} state_t;
    typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_WDATA} phase_t;

    // ============================================================
    // command decoding
    function automatic logic cmd_is_setting(input logic [7:0] c);
        return (c == NV_SETTING_FIRST_OFS) || (c == NV_SETTING_SECOND_OFS);
    endfunction : cmd_is_setting

    function automatic logic cmd_is_override(input logic [7:0] c);
        return c[7:3] == OVR_PREFIX;
    endfunction : cmd_is_override

    // pin view code shares the override prefix, so it is valid through it
    function automatic logic cmd_is_valid(input logic [7:0] c);
        return cmd_is_setting(c) || cmd_is_override(c);
    endfunction : cmd_is_valid

    // ============================================================
    // pin synchronisation and bus edges
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic strap_h;
    logic strap_l;
    logic wp_s;
    logic pick1_s;
    logic pick0_s;
    logic [EXT_WIDTH-1:0] ext_s;

    assign pins_raw = {scl_in, sda_in, addr_strap_high, addr_strap_low, write_lock,
                       source_pick_1, source_pick_0, ext_in};

    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .reset(reset),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign {scl_s, sda_s, strap_h, strap_l, wp_s, pick1_s, pick0_s, ext_s} = pins_s;

    logic scl_d_q;
    logic sda_d_q;

    // resets to the synchroniser's reset level, so no false stop follows reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_d_q <= 1'h0;
            sda_d_q <= 1'h0;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s & ~scl_d_q;
    assign scl_fall = ~scl_s & scl_d_q;
    assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

    // ============================================================
    // state
    state_t st_q;
    phase_t ph_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic rd_q;
    logic mack_q;
    logic [7:0] command_pointer_q;
    logic ptr_q;
    logic ovr_en_q;
    src_t ovr_src_q;
    logic [NV_WIDTH-1:0] pend_first_q;
    logic [NV_WIDTH-1:0] pend_second_q;
    logic [1:0] pend_v_q;
    logic [1:0] wr_cnt_q;
    logic discard_q;
    logic [NV_WIDTH-1:0] nv_setting_first_q;
    logic [NV_WIDTH-1:0] nv_setting_second_q;
    logic [BUSY_W-1:0] busy_cnt_q;

    logic busy;
    logic byte_end;
    logic addr_ok;
    logic cmd_ok;
    logic data_ok;
    logic byte_ack;
    logic cmd_take;
    logic data_take;
    logic data_overrun;
    logic rd_load;
    logic commit;
    logic [7:0] rd_byte;

    assign busy = busy_cnt_q != '0;
    assign byte_end = (st_q == ST_RECV) && scl_fall && (cnt_q == 4'h8);

    assign addr_ok = (ph_q == PH_ADDR) && (shift_q[7:1] == {ADDR_HIGH, strap_h, strap_l}) && !busy;
    assign cmd_ok = (ph_q == PH_CMD) && cmd_is_valid(shift_q);
    assign data_ok = (ph_q == PH_WDATA) && cmd_is_setting(command_pointer_q) && !wp_s
                     && (wr_cnt_q != 2'h2) && !discard_q;
    assign byte_ack = addr_ok || cmd_ok || data_ok;
    assign cmd_take = byte_end && cmd_ok;
    assign data_take = byte_end && data_ok;
    assign data_overrun = byte_end && (ph_q == PH_WDATA) && cmd_is_setting(command_pointer_q)
                          && (wr_cnt_q == 2'h2);
    assign rd_load = scl_fall && (((st_q == ST_ACK) && rd_q) || ((st_q == ST_MACK) && mack_q));

    assign rd_byte = (command_pointer_q == PIN_INPUT_SNAPSHOT_OFS) ? {3'h0, ext_s}
                   : {2'h0, ptr_q ? nv_setting_second_q : nv_setting_first_q};

    // open drain: data is always low, enable decides
    assign sda_out = 1'h0;
    assign sda_oe_n = ~((st_q == ST_ACK) || ((st_q == ST_SEND) && !tx_q[7]));

    // ============================================================
    // bus bit engine
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= ST_IDLE;
            ph_q <= PH_ADDR;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'hFF;
            rd_q <= 1'h0;
            mack_q <= 1'h0;
        end else if (start_det) begin
            st_q <= ST_RECV;
            ph_q <= PH_ADDR;
            cnt_q <= 4'h0;
            rd_q <= 1'h0;
        end else if (stop_det) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE, ST_WAIT: begin
                    st_q <= st_q;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        st_q <= byte_ack ? ST_ACK : ST_WAIT;
                        if (ph_q == PH_ADDR) begin
                            rd_q <= shift_q[0] == RW_READ;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rd_q) begin
                            st_q <= ST_SEND;
                            tx_q <= rd_byte;
                        end else begin
                            st_q <= ST_RECV;
                            ph_q <= (ph_q == PH_ADDR) ? PH_CMD : PH_WDATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        tx_q <= {tx_q[6:0], 1'h1};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            st_q <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        st_q <= mack_q ? ST_SEND : ST_WAIT;
                        if (mack_q) begin
                            tx_q <= rd_byte;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // command register, pointer and override
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            command_pointer_q <= CMD_RESET;
            ptr_q <= 1'h0;
            ovr_en_q <= 1'h0;
            ovr_src_q <= SRC_FIRST;
        end else if (cmd_take) begin
            command_pointer_q <= shift_q;
            if (!cmd_is_override(shift_q)) begin
                ptr_q <= shift_q[0];
            end
            // low bit hands back to pins
            if (cmd_is_override(shift_q)) begin
                ovr_en_q <= !shift_q[OVR_RESTORE_BIT];
                if (shift_q[OVR_PINS_BIT]) begin
                    ovr_src_q <= SRC_PINS;
                end else begin
                    ovr_src_q <= shift_q[OVR_SECOND_BIT] ? SRC_SECOND : SRC_FIRST;
                end
            end
        end else if (data_take || (rd_load && command_pointer_q != PIN_INPUT_SNAPSHOT_OFS)) begin
            ptr_q <= ~ptr_q;
        end
    end

    // ============================================================
    // write staging, committed only by stop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_first_q <= NV_RESET;
            pend_second_q <= NV_RESET;
            pend_v_q <= 2'h0;
            wr_cnt_q <= 2'h0;
            discard_q <= 1'h0;
        end else if (start_det || stop_det) begin
            pend_v_q <= 2'h0;
            wr_cnt_q <= 2'h0;
            discard_q <= 1'h0;
        end else if (data_take) begin
            if (ptr_q) begin
                pend_second_q <= shift_q[NV_WIDTH-1:0];
            end else begin
                pend_first_q <= shift_q[NV_WIDTH-1:0];
            end
            pend_v_q[ptr_q] <= 1'h1;
            wr_cnt_q <= wr_cnt_q + 2'h1;
        end else if (data_overrun) begin
            discard_q <= 1'h1;
        end
    end

    assign commit = stop_det && (pend_v_q != 2'h0) && !discard_q && !wp_s;

    // ============================================================
    // settings and programming busy
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nv_setting_first_q <= NV_RESET;
            nv_setting_second_q <= NV_RESET;
        end else if (commit) begin
            if (pend_v_q[0]) begin
                nv_setting_first_q <= pend_first_q;
            end
            if (pend_v_q[1]) begin
                nv_setting_second_q <= pend_second_q;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_cnt_q <= '0;
        end else if (commit) begin
            busy_cnt_q <= BUSY_W'(PROG_CYCLES);
        end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
        end
    end

    out_mux u_mux (
        .clk(clk),
        .reset(reset),
        .nv_first(nv_setting_first_q),
        .nv_second(nv_setting_second_q),
        .ext_in(ext_s),
        .pick0(pick0_s),
        .pick1(pick1_s),
        .ovr_en(ovr_en_q),
        .ovr_src(ovr_src_q),
        .mux_out(mux_out),
        .nonmux_out(nonmux_out)
    );

    // ============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_busy_nack: assert property (byte_end && ph_q == PH_ADDR && busy |=> st_q == ST_WAIT)
        else $error("address acknowledged while programming");
    chk_commit_busy: assert property (commit |=> busy_cnt_q == BUSY_W'(PROG_CYCLES))
        else $error("busy period not started at commit");
    chk_lock_keeps: assert property (wp_s |=> $stable(nv_setting_first_q) && $stable(nv_setting_second_q))
        else $error("settings changed while locked");
    chk_third_nack: assert property (data_overrun |=> st_q == ST_WAIT && discard_q)
        else $error("third data byte not refused");
    chk_bad_cmd: assert property (byte_end && ph_q == PH_CMD && !cmd_is_valid(shift_q)
        |=> st_q == ST_WAIT && $stable(command_pointer_q))
        else $error("reserved command accepted");
    chk_ptr_toggle: assert property (data_take |=> ptr_q != $past(ptr_q))
        else $error("pointer did not advance");
    chk_pins_view: assert property (rd_load && command_pointer_q == PIN_INPUT_SNAPSHOT_OFS
        |=> tx_q[7:5] == 3'h0)
        else $error("input view upper bits not zero");
    chk_ack_drive: assert property (byte_end && byte_ack |=> !sda_oe_n [*2])
        else $error("acknowledge not driven");
    chk_dir_read: assert property (byte_end && addr_ok && shift_q[0] |=> rd_q)
        else $error("read direction not taken");
endmodule : nv_switch_core
`default_nettype wire

// file: logic/nv_switch_pkg.sv
// shared codes, field layout and timing for the configuration switch
// assumes a 200 MHz core clock; no other context needed
package nv_switch_pkg;
    // ============================================================
    // register offsets, reached as command codes
    localparam logic [7:0] NV_SETTING_FIRST_OFS = 8'h00;
    localparam logic [7:0] NV_SETTING_SECOND_OFS = 8'h01;
    localparam logic [7:0] PIN_INPUT_SNAPSHOT_OFS = 8'hFF;
    // ============================================================
    // source override command layout
    localparam logic [4:0] OVR_PREFIX = 5'h1F;
    localparam int OVR_RESTORE_BIT = 0;
    localparam int OVR_PINS_BIT = 1;
    localparam int OVR_SECOND_BIT = 2;
    // ============================================================
    // field layout and reset values
    localparam int NV_WIDTH = 6;
    localparam int EXT_WIDTH = 5;
    localparam int NONMUX_BIT = 5;
    localparam logic [5:0] NV_RESET = 6'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [4:0] ADDR_HIGH_DEFAULT = 5'h0C;
    localparam logic RW_READ = 1'h1;
    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int NV_PROG_TIME_NS = 3_600_000;
    localparam int NV_PROG_CYCLES = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ============================================================
    // output source
    typedef enum logic [1:0] {SRC_FIRST, SRC_SECOND, SRC_PINS} src_t;
endpackage : nv_switch_pkg

// file: logic/out_mux.sv
// output source selection and the latched extra output
// assumes all inputs already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module out_mux (
    input wire logic clk,
    input wire logic reset,
    input wire logic [nv_switch_pkg::NV_WIDTH-1:0] nv_first,
    input wire logic [nv_switch_pkg::NV_WIDTH-1:0] nv_second,
    input wire logic [nv_switch_pkg::EXT_WIDTH-1:0] ext_in,
    input wire logic pick0,
    input wire logic pick1,
    input wire logic ovr_en,
    input wire nv_switch_pkg::src_t ovr_src,
    output logic [nv_switch_pkg::EXT_WIDTH-1:0] mux_out,
    output logic nonmux_out
);
    import nv_switch_pkg::*;

    src_t src;

    always_comb begin
        if (ovr_en) begin
            src = ovr_src;
        end else if (pick0) begin
            src = SRC_PINS;
        end else if (pick1) begin
            src = SRC_FIRST;
        end else begin
            src = SRC_SECOND;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mux_out <= '0;
            nonmux_out <= 1'h0;
        end else begin
            unique case (src)
                SRC_FIRST: begin
                    mux_out <= nv_first[EXT_WIDTH-1:0];
                    nonmux_out <= nv_first[NONMUX_BIT];
                end
                SRC_SECOND: begin
                    mux_out <= nv_second[EXT_WIDTH-1:0];
                    nonmux_out <= nv_second[NONMUX_BIT];
                end
                SRC_PINS: begin
                    mux_out <= ext_in;
                end
                default: begin
                    mux_out <= mux_out;
                end
            endcase
        end
    end

    chk_pins_ext: assert property (@(posedge clk) disable iff (reset)
        (pick0 && !ovr_en) |=> (mux_out == $past(ext_in)))
        else $error("outputs do not follow external inputs");
    chk_nonmux_hold: assert property (@(posedge clk) disable iff (reset)
        (src == SRC_PINS) |=> $stable(nonmux_out))
        else $error("extra output changed while latched");
endmodule : out_mux
`default_nettype wire

// file: logic/pin_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
// assumes every bit is an independent level
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync WIDTH must be at least one");
    end

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// file: test/bus_master_model.sv
// serial bus master model: clock and open-drain data pull
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // ==================================================
    // bit level, 24 ns per clock half
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // every bit task starts with the clock already low
    task automatic put_bit(input logic b);
        #6 sda_low = ~b;
        #18 scl = 1'b1;
        #24 scl = 1'b0;
    endtask : put_bit
    task automatic get_bit(output logic b);
        #6 sda_low = 1'b0;
        #18 scl = 1'b1;
        #12 b = sda;
        #12 scl = 1'b0;
    endtask : get_bit
    // ==================================================
    // framing; clock stands high between frames
    task automatic start();
        sda_low = 1'b0;
        #24 scl = 1'b1;
        #24 sda_low = 1'b1;
        #24 scl = 1'b0;
    endtask : start
    task automatic stop();
        #6 sda_low = 1'b1;
        #18 scl = 1'b1;
        #24 sda_low = 1'b0;
        #24;
    endtask : stop
    // address byte is sent msb first
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic bit_v;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(bit_v);
        ack = ~bit_v;
    endtask : wbyte
    task automatic rbyte(input logic mack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(~mack);
    endtask : rbyte
endmodule : bus_master_model
`default_nettype wire

// file: test/i2c_nv_switch_command_logic_tb_top.sv
// self-checking bench for the configuration switch core
// assumes bus_master_model and the design files are compiled first
`timescale 1ns/100ps
`default_nettype none
module i2c_nv_switch_command_logic_tb_top;
    import nv_switch_pkg::*;
    localparam int PROG = 200;
    localparam logic [6:0] DEV = {ADDR_HIGH_DEFAULT, 2'b10};
    logic clk, reset, scl, m_low, sda, sda_out, sda_oe_n, write_lock, pick0, pick1, nonmux_out;
    logic [4:0] ext_in, mux_out, acks;
    logic [7:0] rd0, rd1;
    int fail_count = 0;
    int check_count = 0;
    // pull-up wins unless someone pulls low
    assign sda = (!sda_oe_n || m_low) ? 1'b0 : 1'b1;
    nv_switch_core #(.PROG_CYCLES(PROG)) DUT (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_low(1'b0), .addr_strap_high(1'b1),
        .write_lock(write_lock), .source_pick_0(pick0), .source_pick_1(pick1), .ext_in(ext_in),
        .mux_out(mux_out), .nonmux_out(nonmux_out));
    bus_master_model master (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==================================================
    // helpers
    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk
    task automatic pins(input logic p0, input logic p1);
        @(negedge clk);
        pick0 = p0;
        pick1 = p1;
        wait_clk(10);
    endtask : pins
    task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input int n, input logic [23:0] d);
        acks = 5'h00;
        master.start();
        master.wbyte({a, 1'b0}, acks[0]);
        master.wbyte(cmd, acks[1]);
        for (int i = 0; i < n; i++) begin
            master.wbyte(d[23-8*i -: 8], acks[2+i]);
        end
        master.stop();
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input int n);
        wr(DEV, cmd, 0, 24'h0);
        master.start();
        master.wbyte({DEV, RW_READ}, acks[0]);
        master.rbyte(n > 1, rd0);
        if (n > 1) begin
            master.rbyte(1'b0, rd1);
        end
        master.stop();
    endtask : rd
    // ==================================================
    // scenarios
    task automatic t_write_read();
        wr({ADDR_HIGH_DEFAULT, 2'b01}, 8'h00, 0, 24'h0);
        check({7'h0, acks[0]}, 8'h00);
        wr(DEV, NV_SETTING_FIRST_OFS, 2, 24'hEA1500);
        check({3'h0, acks}, 8'h0F);
        wait_clk(PROG + 50);
        pins(1'b0, 1'b1);
        check({2'h0, nonmux_out, mux_out}, 8'h2A);
        pins(1'b1, 1'b1);
        check({3'h0, mux_out}, 8'h13);
        pins(1'b0, 1'b0);
        check({2'h0, nonmux_out, mux_out}, 8'h15);
        rd(NV_SETTING_FIRST_OFS, 2);
        check(rd0, 8'h2A);
        check(rd1, 8'h15);
    endtask : t_write_read
    task automatic t_busy();
        wr(DEV, NV_SETTING_SECOND_OFS, 1, 24'h070000);
        wr(DEV, NV_SETTING_SECOND_OFS, 0, 24'h0);
        check({7'h0, acks[0]}, 8'h00);
        wait_clk(PROG + 50);
        check({2'h0, nonmux_out, mux_out}, 8'h07);
        rd(NV_SETTING_SECOND_OFS, 2);
        check(rd0, 8'h07);
        check(rd1, 8'h2A);
    endtask : t_busy
    task automatic t_refusals();
        logic [7:0] codes [3] = '{8'h02, 8'h80, 8'hF7};
        foreach (codes[i]) begin
            wr(DEV, codes[i], 0, 24'h0);
            check({7'h0, acks[1]}, 8'h00);
        end
        wr(DEV, NV_SETTING_FIRST_OFS, 3, 24'h010203);
        check({3'h0, acks}, 8'h0F);
        @(negedge clk);
        write_lock = 1'b1;
        wr(DEV, NV_SETTING_FIRST_OFS, 1, 24'h3F0000);
        check({3'h0, acks}, 8'h03);
        wait_clk(PROG + 50);
        write_lock = 1'b0;
        rd(NV_SETTING_FIRST_OFS, 2);
        check(rd0, 8'h2A);
        check(rd1, 8'h07);
        rd(PIN_INPUT_SNAPSHOT_OFS, 1);
        check({7'h0, acks[1]}, 8'h01);
        check(rd0, {3'h0, ext_in});
    endtask : t_refusals
    task automatic t_override();
        logic [7:0] codes [4] = '{8'hFC, 8'hFA, 8'hFE, 8'hF8};
        logic [4:0] exp [4] = '{5'h07, 5'h13, 5'h13, 5'h0A};
        pins(1'b0, 1'b1);
        foreach (codes[i]) begin
            wr(DEV, codes[i], 1, 24'hAA0000);
            check({3'h0, acks}, 8'h03);
            wait_clk(10);
            check({3'h0, mux_out}, {3'h0, exp[i]});
        end
        pins(1'b0, 1'b0);
        check({3'h0, mux_out}, 8'h0A);
        wr(DEV, 8'hF9, 0, 24'h0);
        wait_clk(10);
        check({3'h0, mux_out}, 8'h07);
    endtask : t_override
    // ==================================================
    // main sequence and watchdog
    initial begin
        reset = 1'b1;
        write_lock = 1'b0;
        pick0 = 1'b0;
        pick1 = 1'b0;
        ext_in = 5'h13;
        wait_clk(20);
        reset = 1'b0;
        wait_clk(20);
        t_write_read();
        t_busy();
        t_refusals();
        t_override();
        finish_test();
    end
    initial begin
        #400_000;
        fail_count++;
        finish_test();
    end
endmodule : i2c_nv_switch_command_logic_tb_top
`default_nettype wire
